// *** verification/cpu_register_ops_alignment_test.sv ***
/*
 self-checking bench for reg_ops_datapath, one task per scenario.
 assumes mem_partner on the memory port and apb access to the registers.
*/
`timescale 1ns/10ps
module cpu_register_ops_alignment_test
   import reg_ops_pkg::*;
;
   logic              ref_clk_in, resetn_in, psel_in, penable_in, pwrite_in;
   logic [7:0]        paddr_in;
   logic [31:0]       pwdata_in, prdata_out, mem_rdata_in, mem_addr_out, mem_wdata_out;
   logic              pready_out, pslverr_out, mem_ack_in, mem_req_out;
   logic              mem_we_out, mem_wide_out, object_mode_out, slow;
   logic [PC_W-1:0]   pc_in;
   int                err_total, checks_done;

   reg_ops_datapath u_dut (.ref_clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .pc_in,
      .mem_rdata_in, .mem_ack_in, .mem_req_out, .mem_we_out, .mem_wide_out,
      .mem_addr_out, .mem_wdata_out, .object_mode_out);
   mem_partner u_mem (.ref_clk_in, .resetn_in, .req_in(mem_req_out), .we_in(mem_we_out),
      .wide_in(mem_wide_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .slow_in(slow), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

   // -----------------------------------------------------------------
   // bus and compare tasks
   // -----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge ref_clk_in);
      psel_in   <= 1'b1;
      pwrite_in <= w;
      paddr_in  <= a;
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      do @(posedge ref_clk_in); while (pready_out !== 1'b1);
      r = prdata_out;
      e = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic e;
      apb(1'b0, a, 32'h0000_0000, v, e);
   endtask
   task automatic cmd(input op_t op, input logic [2:0] sel, input logic [31:0] imm,
                      input logic [7:0] hi);
      logic [31:0] r;
      logic        e;
      apb(1'b1, A_IMM, imm, r, e);
      apb(1'b1, A_CMD, {16'h0000, hi, sel, op}, r, e);
      do rd(A_STAT, r); while (r[STAT_BUSY_BIT] !== 1'b0);
   endtask
   task automatic cx(input op_t op, input logic [2:0] sel, input logic [31:0] imm,
                     input logic [7:0] hi, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      cmd(op, sel, imm, hi);
      rd(a, v);
      chk(op.name(), e, v);
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset_refuse();
      logic [31:0] v;
      logic        e;
      rd(A_PTR, v);
      chk("ptr reset", {16'h0000, SP_RESET}, v);
      chk("obj pin reset", 32'h0000_0000, {31'h0, object_mode_out});
      cx(OP_SET_OBJ, 0, 0, 0, A_STAT, 32'h0000_0002);
      chk("obj pin set", 32'h0000_0001, {31'h0, object_mode_out});
      apb(1'b0, 8'h1C, 0, v, e);
      chk("unmapped err", 32'h0000_0001, {31'h0, e});
      apb(1'b1, A_STAT, 32'hFFFF_FFFF, v, e);
      chk("ro write err", 32'h0000_0001, {31'h0, e});
      $display("test reset_refuse done");
   endtask
   task automatic t_aux();
      cx(OP_LOAD_XAR22, 3, 32'hFFFF_FFFF, 0, A_XAR, 32'h003F_FFFF);
      cx(OP_ZERO_EXTEND_LOAD_AR, 3, 32'h1234_ABCD, 0, A_XAR, 32'h0000_ABCD);
      cx(OP_HALF_AR, 3, 32'h0000_5555, 1, A_XAR, 32'h5555_ABCD);
      cx(OP_HALF_AR, 3, 32'h0000_1111, 0, A_XAR, 32'h5555_1111);
      cx(OP_ADD_SHORT_CONST_XAR, 3, 32'h0000_00FF, 0, A_XAR, 32'h5555_1190);
      cx(OP_SUB_SHORT_CONST_XAR, 3, 32'h0000_0091, 0, A_XAR, 32'h5555_117F);
      cx(OP_LOAD_XAR22, 7, 32'h0000_FF80, 0, A_XAR, 32'h0000_FF80);
      cx(OP_SET_ARP, 0, 32'h0000_0007, 0, A_STAT, 32'h0000_003A);
      cx(OP_ADD_CUR, 7, 32'h0000_01FF, 0, A_XAR, 32'h0001_007F);
      cx(OP_SUB_CUR, 7, 32'h0000_0180, 0, A_XAR, 32'h0000_FFFF);
      @(posedge ref_clk_in);
      pc_in <= 22'h2A_5A5A;
      cx(OP_SAVE_PC, 1, 0, 0, A_XAR, 32'h002A_5A5A);
      $display("test aux done");
   endtask
   task automatic t_dp_sp();
      cx(OP_WORD_PAGE_LOAD_DP, 0, 32'h0000_FFFF, 0, A_PTR, 32'hFFFF_0400);
      cx(OP_DP10, 0, 32'h0000_0000, 0, A_PTR, 32'hFC00_0400);
      cx(OP_ZERO_EXTEND_LOAD_DP, 0, 32'h0000_FFFF, 0, A_PTR, 32'h03FF_0400);
      cx(OP_SP_ADD, 0, 32'h0000_00FF, 0, A_PTR, 32'h03FF_047F);
      cx(OP_SP_SUB, 0, 32'h0000_007F, 0, A_PTR, 32'h03FF_0400);
      $display("test dp_sp done");
   endtask
   task automatic t_acc();
      logic [31:0] ex [8] = '{32'h0000_0040, 32'hFFFF_FFC0, 32'h0000_00C0, 32'hFFFF_FFC0,
                             32'h0000_03C0, 32'h0000_FFC0, 32'hFFFF_FFC0, 32'h0000_FFC0};
      for (int k = 0; k < 8; k++) begin
         cx(OP_ACC_EXT, 0, 32'h0000_FFC0, {4'h0, k[2:0], 1'b0}, A_ACC, ex[k]);
      end
      cx(OP_ACC_HALF, 0, 32'h0000_1234, 1, A_ACC, 32'h1234_FFC0);
      cx(OP_ACC_HALF, 0, 32'h0000_5678, 0, A_ACC, 32'h1234_5678);
      $display("test acc done");
   endtask
   task automatic t_align();
      cmd(OP_LOAD_XAR22, 7, 32'h0000_0005, 0);
      cx(OP_ST32, 7, 0, 0, A_XAR, 32'h0000_0005);
      chk("mem addr", 32'h0000_0004, mem_addr_out);
      chk("low word", 32'h0000_5678, {16'h0000, u_mem.mem[4]});
      chk("high word", 32'h0000_1234, {16'h0000, u_mem.mem[5]});
      slow <= 1'b1;
      cx(OP_LD32, 2, 0, 0, A_XAR, 32'h1234_5678);
      $display("test align done");
   endtask
   task automatic t_stack();
      logic [31:0] v, p;
      logic [15:0] a;
      logic        w;
      for (int s = 0; s < 12; s++) begin
         slow <= s[0];
         cmd(OP_NOP, 0, 0, {s[3:0], 4'h0});
         rd(A_VIEW, v);
         rd(A_PTR, p);
         w = !(s inside {4, 5, 6, 7, 8});
         a = w ? (p[15:0] & 16'hFFFE) : p[15:0];
         cx(OP_PUSH, 0, 0, {s[3:0], 4'h0}, A_PTR, p + (w ? 2 : 1));
         chk("push low", {16'h0000, v[15:0]}, {16'h0000, u_mem.mem[a[11:0]]});
         chk("push wide", {31'h0, w}, {31'h0, mem_wide_out});
         chk("push we", 32'h0000_0001, {31'h0, mem_we_out});
         if (w) chk("push high", {16'h0000, v[31:16]}, {16'h0000, u_mem.mem[a[11:0] + 1]});
      end
      cmd(OP_ACC_HALF, 0, 0, 0);
      for (int s = 11; s >= 0; s--) begin
         cmd(OP_POP, 0, 0, {s[3:0], 4'h0});
      end
      rd(A_PTR, v);
      chk("ptr after pop", 32'h03FF_0400, v);
      rd(A_ACC, v);
      chk("acc after pop", 32'h1234_5678, v);
      $display("test stack done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      #1_000_000;
      err_total++;
      complete_run();
   end
   initial begin
      {resetn_in, psel_in, penable_in, pwrite_in, slow} = '0;
      paddr_in  = 8'h00;
      pwdata_in = 32'h0000_0000;
      pc_in     = '0;
      repeat (8) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      t_reset_refuse();
      t_aux();
      t_dp_sp();
      t_acc();
      t_align();
      t_stack();
      complete_run();
   end
endmodule

// *** verification/mem_partner.sv ***
/*
 memory model for the datapath memory port: 16-bit words, one answer
 per request after one or five cycles.
 assumes one request outstanding and address held until the answer.
*/
`timescale 1ns/10ps
module mem_partner (
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   input  wire logic        req_in,
   input  wire logic        we_in,
   input  wire logic        wide_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        slow_in,
   output logic             ack_out,
   output logic [31:0]      rdata_out
);
   logic [15:0] mem [0:4095];
   logic        pend;
   logic [2:0]  wait_cnt;
   wire  [11:0] a = addr_in[11:0];

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend      <= 1'b0;
         wait_cnt  <= 3'h0;
         ack_out   <= 1'b0;
         rdata_out <= 32'h0000_0000;
      end else begin
         ack_out   <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in) begin
            pend     <= 1'b1;
            wait_cnt <= slow_in ? 3'h4 : 3'h0;
         end else if (pend && wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
         end else if (pend) begin
            pend    <= 1'b0;
            ack_out <= 1'b1;
            if (we_in) begin
               mem[a] <= wdata_in[15:0];
               if (wide_in) begin
                  mem[a + 12'h001] <= wdata_in[31:16];
               end
            end else begin
               rdata_out <= {wide_in ? mem[a + 12'h001] : 16'h0000, mem[a]};
            end
         end
      end
   end
endmodule

// *** verilog/reg_ops_datapath.sv ***
/*
 register-operation datapath: auxiliary, page, stack and accumulator
 register updates, immediate extension, aligned 32-bit memory access
 and push/pop, driven by commands written over apb.
 assumes the memory answers each mem_req_out with one mem_ack_in pulse
 in a later cycle, on the same clock.
*/
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

module reg_ops_datapath
   import reg_ops_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              resetn_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [7:0]        paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic                   pready_out,
   output logic [31:0]            prdata_out,
   output logic                   pslverr_out,
   input  wire logic [PC_W-1:0]   pc_in,
   input  wire logic [31:0]       mem_rdata_in,
   input  wire logic              mem_ack_in,
   output logic                   mem_req_out,
   output logic                   mem_we_out,
   output logic                   mem_wide_out,
   output logic [31:0]            mem_addr_out,
   output logic [31:0]            mem_wdata_out,
   output logic                   object_mode_out
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [31:0]        xar_reg [AUX_COUNT];
   logic [31:0]        xar_next [AUX_COUNT];
   logic [31:0]        acc_reg, acc_next, p_reg, p_next, xt_reg, xt_next;
   logic [31:0]        rpc_reg, rpc_next, cmd_reg, cmd_next, imm_reg, imm_next;
   logic [15:0]        st0_reg, st0_next, st1_reg, st1_next, dp_reg, dp_next;
   logic [15:0]        ifr_reg, ifr_next, debug_interrupt_enable_reg_reg, debug_interrupt_enable_reg_next, sp_reg, sp_next;
   state_t             state_reg, state_next;
   logic               mem_req_reg, mem_req_next, mem_we_reg, mem_we_next;
   logic               mem_wide_reg, mem_wide_next;
   logic [31:0]        mem_addr_reg, mem_addr_next, mem_wdata_reg, mem_wdata_next;
   logic               pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [31:0]        prdata_reg, prdata_next;

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   logic               acc_done, go;
   logic [31:0]        cw;
   op_t                op;
   logic [SEL_W-1:0]   sel, aux_reg_pointer_field;
   logic               half;
   ext_t               ek;
   src_t               src;
   logic [32:0]        src_w;
   logic [15:0]        step;

   assign acc_done = psel_in & penable_in & pready_reg;
   assign go       = acc_done & pwrite_in & (paddr_in == A_CMD) & (state_reg == ST_IDLE);
   assign cw       = go ? pwdata_in : cmd_reg;
   assign op       = op_t'(cw[CMD_OP_LSB +: OP_W]);
   assign sel      = cw[CMD_SEL_LSB +: SEL_W];
   assign half     = cw[CMD_HALF_BIT];
   assign ek       = ext_t'(cw[CMD_EXT_LSB +: EXT_W]);
   assign src      = src_t'(cw[CMD_SRC_LSB +: SRC_W]);
   assign aux_reg_pointer_field      = st1_reg[ST1_ARP_LSB +: SEL_W];
   assign src_w    = src_word(src);
   assign step     = src_w[32] ? STEP_WIDE : STEP_WORD;

   function automatic logic [31:0] ext_imm(input logic [31:0] v, input ext_t k);
      case (k)
         EXT_Z7:  ext_imm = {{25{1'b0}}, v[6:0]};
         EXT_S7:  ext_imm = {{25{v[6]}}, v[6:0]};
         EXT_Z8:  ext_imm = {{24{1'b0}}, v[7:0]};
         EXT_S8:  ext_imm = {{24{v[7]}}, v[7:0]};
         EXT_Z10: ext_imm = {{22{1'b0}}, v[9:0]};
         EXT_Z16: ext_imm = {{16{1'b0}}, v[15:0]};
         EXT_S16: ext_imm = {{16{v[15]}}, v[15:0]};
         default: ext_imm = {{10{1'b0}}, v[21:0]};
      endcase
   endfunction

   // width flag in bit 32, value below; pairs put the first-named high
   function automatic logic [32:0] src_word(input src_t s);
      case (s)
         SRC_ACC:     src_word = {1'b1, acc_reg};
         SRC_P:       src_word = {1'b1, p_reg};
         SRC_XT:      src_word = {1'b1, xt_reg};
         SRC_DP_ST1:  src_word = {1'b1, dp_reg, st1_reg};
         SRC_ST0:     src_word = {1'b0, 16'h0000, st0_reg};
         SRC_ST1:     src_word = {1'b0, 16'h0000, st1_reg};
         SRC_DP:      src_word = {1'b0, 16'h0000, dp_reg};
         SRC_IFR:     src_word = {1'b0, 16'h0000, ifr_reg};
         SRC_DEBUG_INTERRUPT_ENABLE_REG:  src_word = {1'b0, 16'h0000, debug_interrupt_enable_reg_reg};
         SRC_RPC:     src_word = {1'b1, rpc_reg};
         SRC_XAR:     src_word = {1'b1, xar_reg[sel]};
         SRC_AR1_AR0: src_word = {1'b1, xar_reg[1][15:0], xar_reg[0][15:0]};
         default:     src_word = {1'b0, 32'h0000_0000};
      endcase
   endfunction

   // ------------------------------------------------------------------
   // datapath and memory sequencer
   // ------------------------------------------------------------------
   always_comb begin
      xar_next = xar_reg;
      acc_next = acc_reg;
      p_next = p_reg;
      xt_next = xt_reg;
      rpc_next = rpc_reg;
      st0_next = st0_reg;
      st1_next = st1_reg;
      dp_next = dp_reg;
      ifr_next = ifr_reg;
      debug_interrupt_enable_reg_next = debug_interrupt_enable_reg_reg;
      sp_next = sp_reg;
      cmd_next = cmd_reg;
      state_next = state_reg;
      mem_req_next = 1'b0;
      mem_we_next = mem_we_reg;
      mem_wide_next = mem_wide_reg;
      mem_addr_next = mem_addr_reg;
      mem_wdata_next = mem_wdata_reg;
      case (state_reg)
         ST_IDLE: if (go) begin
            cmd_next = pwdata_in;
            case (op)
               OP_ADD_SHORT_CONST_XAR:   xar_next[sel] = xar_reg[sel] + ext_imm(imm_reg, EXT_Z7);
               OP_SUB_SHORT_CONST_XAR:   xar_next[sel] = xar_reg[sel] - ext_imm(imm_reg, EXT_Z7);
               OP_ADD_CUR:    xar_next[aux_reg_pointer_field] = xar_reg[aux_reg_pointer_field] + ext_imm(imm_reg, EXT_Z8);
               OP_SUB_CUR:    xar_next[aux_reg_pointer_field] = xar_reg[aux_reg_pointer_field] - ext_imm(imm_reg, EXT_Z8);
               OP_LOAD_XAR22: xar_next[sel] = ext_imm(imm_reg, EXT_Z22);
               OP_SAVE_PC:    xar_next[sel] = 32'(pc_in);
               OP_ZERO_EXTEND_LOAD_AR:    xar_next[sel] = ext_imm(imm_reg, EXT_Z16);
               OP_HALF_AR: begin
                  if (half) begin
                     xar_next[sel][31:16] = imm_reg[15:0];
                  end else begin
                     xar_next[sel][15:0] = imm_reg[15:0];
                  end
               end
               OP_DP10:       dp_next[DP_LOW_W-1:0] = imm_reg[DP_LOW_W-1:0];
               OP_ZERO_EXTEND_LOAD_DP:    dp_next = 16'(ext_imm(imm_reg, EXT_Z10));
               OP_WORD_PAGE_LOAD_DP:    dp_next = imm_reg[15:0];
               OP_SP_ADD:     sp_next = sp_reg + 16'(ext_imm(imm_reg, EXT_Z7));
               OP_SP_SUB:     sp_next = sp_reg - 16'(ext_imm(imm_reg, EXT_Z7));
               OP_ACC_HALF: begin
                  if (half) begin
                     acc_next[31:16] = imm_reg[15:0];
                  end else begin
                     acc_next[15:0] = imm_reg[15:0];
                  end
               end
               OP_ACC_EXT:    acc_next = ext_imm(imm_reg, ek);
               OP_SET_OBJ:    st1_next[ST1_OBJ_BIT] = 1'b1;
               OP_SET_ARP:    st1_next[ST1_ARP_LSB +: SEL_W] = imm_reg[SEL_W-1:0];
               OP_LD32, OP_ST32: begin
                  // pointer itself is left as it is
                  mem_addr_next = {xar_reg[aux_reg_pointer_field][31:1], 1'b0};
                  mem_wide_next = 1'b1;
                  mem_we_next = (op == OP_ST32);
                  mem_wdata_next = acc_reg;
                  mem_req_next = 1'b1;
                  state_next = ST_REQ;
               end
               OP_PUSH, OP_POP: begin
                  mem_addr_next = 32'((op == OP_PUSH) ? sp_reg : sp_reg - step);
                  if (src_w[32]) begin
                     mem_addr_next[0] = 1'b0;
                  end
                  mem_wide_next = src_w[32];
                  mem_we_next = (op == OP_PUSH);
                  mem_wdata_next = src_w[31:0];
                  mem_req_next = 1'b1;
                  state_next = ST_REQ;
               end
               default: ;
            endcase
         end
         ST_REQ: state_next = ST_WAIT;
         ST_WAIT: if (mem_ack_in) begin
            state_next = ST_IDLE;
            case (op)
               OP_LD32: xar_next[sel] = mem_rdata_in;
               OP_PUSH: sp_next = sp_reg + step;
               OP_POP: begin
                  sp_next = sp_reg - step;
                  case (src)
                     SRC_ACC:     acc_next = mem_rdata_in;
                     SRC_P:       p_next = mem_rdata_in;
                     SRC_XT:      xt_next = mem_rdata_in;
                     SRC_DP_ST1: begin
                        st1_next = mem_rdata_in[15:0];
                        dp_next = mem_rdata_in[31:16];
                     end
                     SRC_ST0:     st0_next = mem_rdata_in[15:0];
                     SRC_ST1:     st1_next = mem_rdata_in[15:0];
                     SRC_DP:      dp_next = mem_rdata_in[15:0];
                     SRC_IFR:     ifr_next = mem_rdata_in[15:0];
                     SRC_DEBUG_INTERRUPT_ENABLE_REG:  debug_interrupt_enable_reg_next = mem_rdata_in[15:0];
                     SRC_RPC:     rpc_next = mem_rdata_in;
                     SRC_XAR:     xar_next[sel] = mem_rdata_in;
                     SRC_AR1_AR0: begin
                        xar_next[0][15:0] = mem_rdata_in[15:0];
                        xar_next[1][15:0] = mem_rdata_in[31:16];
                     end
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < AUX_COUNT; i++) begin
            xar_reg[i] <= '0;
         end
         acc_reg <= '0;
         p_reg <= '0;
         xt_reg <= '0;
         rpc_reg <= '0;
         cmd_reg <= '0;
         st0_reg <= '0;
         st1_reg <= ST1_RESET;
         dp_reg <= '0;
         ifr_reg <= '0;
         debug_interrupt_enable_reg_reg <= '0;
         sp_reg <= SP_RESET;
         state_reg <= ST_IDLE;
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_wide_reg <= 1'b0;
         mem_addr_reg <= '0;
         mem_wdata_reg <= '0;
      end else begin
         xar_reg <= xar_next;
         acc_reg <= acc_next;
         p_reg <= p_next;
         xt_reg <= xt_next;
         rpc_reg <= rpc_next;
         cmd_reg <= cmd_next;
         st0_reg <= st0_next;
         st1_reg <= st1_next;
         dp_reg <= dp_next;
         ifr_reg <= ifr_next;
         debug_interrupt_enable_reg_reg <= debug_interrupt_enable_reg_next;
         sp_reg <= sp_next;
         state_reg <= state_next;
         mem_req_reg <= mem_req_next;
         mem_we_reg <= mem_we_next;
         mem_wide_reg <= mem_wide_next;
         mem_addr_reg <= mem_addr_next;
         mem_wdata_reg <= mem_wdata_next;
      end
   end

   // ------------------------------------------------------------------
   // apb slave, one wait state
   // ------------------------------------------------------------------
   always_comb begin
      pready_next = psel_in & penable_in & ~pready_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      imm_next = imm_reg;
      if (acc_done && pwrite_in && paddr_in == A_IMM) begin
         imm_next = pwdata_in;
      end
      if (pready_next) begin
         prdata_next = '0;
         case (paddr_in)
            A_CMD:  prdata_next = cmd_reg;
            A_IMM:  prdata_next = imm_reg;
            A_STAT: begin
               prdata_next[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
               prdata_next[STAT_OBJ_BIT] = st1_reg[ST1_OBJ_BIT];
               prdata_next[STAT_AMD_BIT] = st1_reg[ST1_ADDRESSING_MODE_BIT_BIT];
               prdata_next[STAT_ARP_LSB +: SEL_W] = aux_reg_pointer_field;
            end
            A_VIEW: prdata_next = src_w[31:0];
            A_XAR:  prdata_next = xar_reg[sel];
            A_PTR:  prdata_next = {dp_reg, sp_reg};
            A_ACC:  prdata_next = acc_reg;
            default: pslverr_next = 1'b1;
         endcase
         if (pwrite_in && paddr_in != A_CMD && paddr_in != A_IMM) begin
            pslverr_next = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_reg <= 1'b0;
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
         imm_reg <= '0;
      end else begin
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         imm_reg <= imm_next;
      end
   end

   assign pready_out = pready_reg;
   assign prdata_out = prdata_reg;
   assign pslverr_out = pslverr_reg;
   assign mem_req_out = mem_req_reg;
   assign mem_we_out = mem_we_reg;
   assign mem_wide_out = mem_wide_reg;
   assign mem_addr_out = mem_addr_reg;
   assign mem_wdata_out = mem_wdata_reg;
   assign object_mode_out = st1_reg[ST1_OBJ_BIT];

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   logic [31:0] cur_aux, sel_aux;
   assign cur_aux = xar_reg[aux_reg_pointer_field];
   assign sel_aux = xar_reg[cmd_reg[CMD_SEL_LSB +: SEL_W]];

   sequence s_go(op_t o);
      go && op == o;
   endsequence
   sequence s_mem_go;
      go && (op == OP_LD32 || op == OP_ST32 || op == OP_PUSH || op == OP_POP);
   endsequence

   a_wide_even_addr: assert property (mem_req_out && mem_wide_out |-> !mem_addr_out[0])
      else $error("wide access at odd address");
   a_pointer_kept: assert property (s_go(OP_ST32) |=> $stable(cur_aux) [*2])
      else $error("pointer changed by wide store");
   a_store_order: assert property (s_go(OP_ST32) |=> mem_req_out && mem_wdata_out[15:0] == $past(acc_reg[15:0]) && mem_addr_out == {$past(cur_aux[31:1]), 1'b0})
      else $error("wide store word order or address wrong");
   a_obj_set: assert property (s_go(OP_SET_OBJ) |=> object_mode_out)
      else $error("object mode not set");
   a_cur_aux_add: assert property (s_go(OP_ADD_CUR) |=> cur_aux == $past(cur_aux) + {24'h00_0000, $past(imm_reg[7:0])})
      else $error("current auxiliary add wrong");
   a_zero_extend_load_aux: assert property (s_go(OP_ZERO_EXTEND_LOAD_AR) |=> sel_aux == {16'h0000, $past(imm_reg[15:0])})
      else $error("zero-extend auxiliary load wrong");
   a_page_zero: assert property (s_go(OP_ZERO_EXTEND_LOAD_DP) |=> dp_reg == {6'b00_0000, $past(imm_reg[9:0])})
      else $error("page load did not clear high bits");
   a_page_word: assert property (s_go(OP_WORD_PAGE_LOAD_DP) |=> dp_reg == $past(imm_reg[15:0]))
      else $error("word page load wrong");
   a_sp_add: assert property (s_go(OP_SP_ADD) |=> sp_reg == $past(sp_reg) + {9'h000, $past(imm_reg[6:0])})
      else $error("stack pointer add wrong");
   a_mem_pulse: assert property (s_mem_go |=> mem_req_out ##1 (!mem_req_out && state_reg == ST_WAIT))
      else $error("memory request not a single pulse");
endmodule

// *** verilog/reg_ops_pkg.sv ***
/*
 register-operation datapath: register map, command fields, op codes,
 immediate extension kinds, stack sources, sequencer states.
 assumes one core clock and an apb slave port with 8-bit byte addresses.
*/
package reg_ops_pkg;
   // -----------------------------------------------------------------
   // register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] A_CMD  = 8'h00;
   localparam logic [7:0] A_IMM  = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_VIEW = 8'h0C;
   localparam logic [7:0] A_XAR  = 8'h10;
   localparam logic [7:0] A_PTR  = 8'h14;
   localparam logic [7:0] A_ACC  = 8'h18;

   // -----------------------------------------------------------------
   // command word fields
   // -----------------------------------------------------------------
   localparam int CMD_OP_LSB   = 0;
   localparam int OP_W         = 5;
   localparam int CMD_SEL_LSB  = 5;
   localparam int SEL_W        = 3;
   localparam int CMD_HALF_BIT = 8;
   localparam int CMD_EXT_LSB  = 9;
   localparam int EXT_W        = 3;
   localparam int CMD_SRC_LSB  = 12;
   localparam int SRC_W        = 4;

   // status_reg_one layout and status word bits
   localparam int ST1_ADDRESSING_MODE_BIT_BIT = 8;
   localparam int ST1_OBJ_BIT   = 9;
   localparam int ST1_ARP_LSB   = 13;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OBJ_BIT  = 1;
   localparam int STAT_AMD_BIT  = 2;
   localparam int STAT_ARP_LSB  = 3;

   // sizes and reset values
   localparam int          AUX_COUNT = 8;
   localparam int          HALF_W    = 16;
   localparam int          DP_LOW_W  = 10;
   localparam int          PC_W      = 22;
   localparam logic [15:0] SP_RESET  = 16'h0400;
   localparam logic [15:0] ST1_RESET = 16'h0000;
   localparam logic [15:0] STEP_WIDE = 16'h0002;
   localparam logic [15:0] STEP_WORD = 16'h0001;

   typedef enum logic [OP_W-1:0] {
      OP_NOP, OP_ADD_SHORT_CONST_XAR, OP_SUB_SHORT_CONST_XAR, OP_ADD_CUR, OP_SUB_CUR, OP_LOAD_XAR22,
      OP_SAVE_PC, OP_ZERO_EXTEND_LOAD_AR, OP_HALF_AR, OP_DP10, OP_ZERO_EXTEND_LOAD_DP, OP_WORD_PAGE_LOAD_DP,
      OP_SP_ADD, OP_SP_SUB, OP_ACC_HALF, OP_ACC_EXT, OP_SET_OBJ, OP_SET_ARP,
      OP_LD32, OP_ST32, OP_PUSH, OP_POP
   } op_t;

   typedef enum logic [EXT_W-1:0] {
      EXT_Z7, EXT_S7, EXT_Z8, EXT_S8, EXT_Z10, EXT_Z16, EXT_S16, EXT_Z22
   } ext_t;

   typedef enum logic [SRC_W-1:0] {
      SRC_ACC, SRC_P, SRC_XT, SRC_DP_ST1, SRC_ST0, SRC_ST1, SRC_DP, SRC_IFR,
      SRC_DEBUG_INTERRUPT_ENABLE_REG, SRC_RPC, SRC_XAR, SRC_AR1_AR0
   } src_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REQ  = 2'b01,
      ST_WAIT = 2'b11
   } state_t;
endpackage
